// >>> scp_top.sv
// Two-wire register port and frame line sequencer of a camera sensor.
// Assumes scl/sda arrive as raw pins and lclk is an unrelated link clock.
//
// Behaviour
// - Slave on a fast-mode two-wire bus.
// - Sixteen-bit register address, eight-bit data.
// - Decode the config block only; reserved and maker blocks read zero.
// - Strap pin picks the slave address.
// - Answer only to the selected address.
// - Direction bit: zero writes, one reads.
// - Data line two-way, clock line input only.
// - Embedded lines carry flagged registers after frame start.
// - Embedded slots still sent when disabled.
// - Rows alternate red and blue kinds.
// - Output starts upper left, row by row.
// - Frame start, embedded lines, rows from line three.
// - Phase-detect, gyro, then frame end lines.
// - Line width and row count follow mode.
// - Unconnected strap reads low, default address.
`timescale 1ns/1ps
module scp_top
    import scp_pkg::*;
#(
    parameter logic [11:0] ROWS_F = scp_pkg::ROWS_FULL,
    parameter logic [11:0] ROWS_B2 = scp_pkg::ROWS_BIN2,
    parameter logic [11:0] ROWS_B4 = scp_pkg::ROWS_BIN4,
    parameter logic [11:0] WIDTH_F = scp_pkg::WIDTH_FULL,
    parameter logic [11:0] WIDTH_B = scp_pkg::WIDTH_BIN
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic lclk,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic addr_select_pin,
    output logic line_valid,
    output scp_pkg::scp_kind_t line_kind,
    output logic [11:0] line_num,
    output logic pix_valid,
    output logic [11:0] pix_idx,
    output logic [7:0] line_data,
    output logic frame_start,
    output logic frame_end
);
    import scp_pkg::*;

    logic [1:0] scl_q;
    logic [1:0] sda_q;
    logic [1:0] sel_q;
    logic scl_d;
    logic sda_d;
    logic scl;
    logic sda;
    logic start_c;
    logic stop_c;
    logic rise_c;
    logic fall_c;
    logic [6:0] my_addr;
    scp_i2c_t st_r;
    logic [3:0] cnt_r;
    logic ack_r;
    logic nack_r;
    logic sda_oe_r;
    logic sda_o_r;
    logic [7:0] sh_r;
    logic [15:0] addr_r;
    logic [REG_DEPTH-1:0][7:0] cfg_r;
    logic [REG_DEPTH-1:0][7:0] snap_r;
    logic [7:0] rd_byte;
    logic in_cfg;
    logic byte_end;
    logic dev_hit;
    logic wr_fire;
    logic [2:0] req_q;
    logic ack_t_r;
    logic lreq_t_r;

    // Pins are sampled twice; scl is never driven.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            scl_q <= 2'h3;
            sda_q <= 2'h3;
            sel_q <= 2'h0;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            scl_q <= {scl_q[0], scl_i};
            sda_q <= {sda_q[0], sda_i};
            sel_q <= {sel_q[0], addr_select_pin};
            scl_d <= scl_q[1];
            sda_d <= sda_q[1];
        end
    end

    assign scl = scl_q[1];
    assign sda = sda_q[1];
    assign start_c = scl && scl_d && sda_d && !sda;
    assign stop_c = scl && scl_d && !sda_d && sda;
    assign rise_c = scl && !scl_d;
    assign fall_c = !scl && scl_d;
    // A floating strap is pulled low, giving the default address.
    assign my_addr = sel_q[1] ? SADDR_HI : SADDR_LO;
    assign in_cfg = (addr_r[15:4] == 12'h000);
    assign byte_end = fall_c && !ack_r && (cnt_r == 4'h8);
    assign dev_hit = (sh_r[7:1] == my_addr);
    assign wr_fire = byte_end && (st_r == S_WR);
    assign sda_o = sda_o_r;
    assign sda_oe = sda_oe_r;

    // Reserved, maker and unbacked config addresses read as zero.
    always_comb
    begin
        rd_byte = 8'h00;
        if (in_cfg)
        begin
            rd_byte = (addr_r[3:0] == IX_ID) ? ID_VAL : cfg_r[addr_r[3:0]];
        end
    end

    // Bus engine: bits are taken on scl rise, sda changes only after scl fall.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            st_r <= S_IDLE;
            cnt_r <= 4'h0;
            ack_r <= 1'b0;
            nack_r <= 1'b0;
            sda_oe_r <= 1'b0;
            sda_o_r <= 1'b0;
            sh_r <= 8'h00;
            addr_r <= 16'h0000;
        end
        else if (start_c)
        begin
            st_r <= S_DEV;
            cnt_r <= 4'h0;
            ack_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end
        else if (stop_c)
        begin
            st_r <= S_IDLE;
            ack_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end
        else if (st_r != S_IDLE)
        begin
            if (rise_c)
            begin
                if (ack_r)
                begin
                    nack_r <= sda;
                end
                else
                begin
                    cnt_r <= cnt_r + 4'h1;
                    if (st_r != S_RD)
                    begin
                        sh_r <= {sh_r[6:0], sda};
                    end
                end
            end
            else if (fall_c)
            begin
                if (ack_r)
                begin
                    ack_r <= 1'b0;
                    cnt_r <= 4'h0;
                    sda_oe_r <= 1'b0;
                    if (st_r == S_RD)
                    begin
                        if (nack_r)
                        begin
                            st_r <= S_IDLE;
                        end
                        else
                        begin
                            sh_r <= rd_byte;
                            sda_oe_r <= !rd_byte[7];
                            addr_r <= addr_r + 16'h0001;
                        end
                    end
                end
                else if (cnt_r == 4'h8)
                begin
                    ack_r <= 1'b1;
                    sda_oe_r <= 1'b1;
                    unique case (st_r)
                        S_DEV:
                        begin
                            if (dev_hit)
                            begin
                                st_r <= sh_r[0] ? S_RD : S_AHI;
                                nack_r <= 1'b0;
                            end
                            else
                            begin
                                st_r <= S_IDLE;
                                ack_r <= 1'b0;
                                sda_oe_r <= 1'b0;
                            end
                        end
                        S_AHI:
                        begin
                            addr_r[15:8] <= sh_r;
                            st_r <= S_ALO;
                        end
                        S_ALO:
                        begin
                            addr_r[7:0] <= sh_r;
                            st_r <= S_WR;
                        end
                        S_WR:
                        begin
                            addr_r <= addr_r + 16'h0001;
                        end
                        S_RD:
                        begin
                            sda_oe_r <= 1'b0;
                        end
                        S_IDLE:
                        begin
                            sda_oe_r <= 1'b0;
                        end
                    endcase
                end
                else if (st_r == S_RD)
                begin
                    sh_r <= {sh_r[6:0], 1'b0};
                    sda_oe_r <= !sh_r[6];
                end
            end
        end
    end

    // Only the backed config bytes other than the identity byte take writes; every other address is acked and dropped.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            cfg_r <= '0;
            // The identity byte sits in the array so that every snapshot carries it.
            cfg_r[IX_ID] <= ID_VAL;
            cfg_r[IX_CTRL] <= CTRL_RST;
            cfg_r[IX_MODE] <= MODE_RST;
        end
        else if (wr_fire && in_cfg && (addr_r[3:0] != IX_ID))
        begin
            cfg_r[addr_r[3:0]] <= sh_r;
        end
    end

    // Snapshot handshake: the copy is frozen until the link asks again.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            req_q <= 3'h0;
            ack_t_r <= 1'b0;
            snap_r <= '0;
        end
        else
        begin
            req_q <= {req_q[1:0], lreq_t_r};
            if (req_q[2] != req_q[1])
            begin
                snap_r <= cfg_r;
                ack_t_r <= ~ack_t_r;
            end
        end
    end

    logic [1:0] lrst_q;
    logic lnrst;
    logic [2:0] ack_q;
    scp_link_t lst_r;
    logic [7:0] gap_r;
    logic emb_on_r;
    logic emb_i_r;
    logic [11:0] rows_r;
    logic [11:0] width_r;
    logic [1:0] mode_s;
    scp_kind_t kind_r;
    scp_kind_t nk;
    logic [11:0] lnum_r;
    logic [11:0] nl;
    logic lval_r;
    logic pval_r;
    logic [11:0] pidx_r;
    logic [7:0] data_r;
    logic fs_r;
    logic fe_r;
    logic [11:0] pnext;

    always_ff @(posedge lclk)
    begin
        lrst_q <= {lrst_q[0], nrst};
    end
    assign lnrst = lrst_q[1];
    assign mode_s = snap_r[IX_MODE][1:0];
    assign pnext = pidx_r + 12'd1;

    // Next line of the frame, from the line just sent.
    always_comb
    begin
        nk = K_FE;
        nl = lnum_r;
        unique case (kind_r)
            K_FS:
            begin
                nk = K_EMB;
                nl = LINE_EMB;
            end
            K_EMB:
            begin
                nk = emb_i_r ? K_RG : K_EMB;
                nl = emb_i_r ? LINE_ROW0 : LINE_EMB;
            end
            K_RG, K_GB:
            begin
                if (lnum_r == rows_r + 12'd2)
                begin
                    nk = K_PD;
                end
                else
                begin
                    nk = (kind_r == K_RG) ? K_GB : K_RG;
                end
                nl = lnum_r + 12'd1;
            end
            K_PD:
            begin
                nk = K_GYRO;
                nl = lnum_r + 12'd1;
            end
            K_GYRO:
            begin
                nk = K_FE;
            end
            K_FE:
            begin
                nk = K_FS;
                nl = LINE_FS;
            end
            default:
            begin
                nk = K_FE;
            end
        endcase
    end

    // Frame sequencer on the link clock.
    always_ff @(posedge lclk)
    begin
        if (!lnrst)
        begin
            ack_q <= 3'h0;
            lreq_t_r <= 1'b0;
            lst_r <= L_REQ;
            gap_r <= 8'h00;
            emb_on_r <= 1'b0;
            emb_i_r <= 1'b0;
            rows_r <= ROWS_F;
            width_r <= WIDTH_F;
            kind_r <= K_FE;
            lnum_r <= 12'h000;
            lval_r <= 1'b0;
            pval_r <= 1'b0;
            pidx_r <= 12'h000;
            data_r <= 8'h00;
            fs_r <= 1'b0;
            fe_r <= 1'b0;
        end
        else
        begin
            ack_q <= {ack_q[1:0], ack_t_r};
            fs_r <= 1'b0;
            fe_r <= 1'b0;
            unique case (lst_r)
                L_REQ:
                begin
                    lreq_t_r <= ~lreq_t_r;
                    lst_r <= L_WAIT;
                end
                L_WAIT:
                begin
                    if (ack_q[2] != ack_q[1])
                    begin
                        if (snap_r[IX_CTRL][CTRL_STREAM])
                        begin
                            emb_on_r <= snap_r[IX_CTRL][CTRL_EMB];
                            rows_r <= (mode_s == MODE_BIN4) ? ROWS_B4 :
                                      (mode_s == MODE_BIN2) ? ROWS_B2 : ROWS_F;
                            width_r <= (mode_s == MODE_FULL) ? WIDTH_F : WIDTH_B;
                            lst_r <= L_FS;
                        end
                        else
                        begin
                            lst_r <= L_REQ;
                        end
                    end
                end
                L_FS:
                begin
                    fs_r <= 1'b1;
                    kind_r <= K_FS;
                    lnum_r <= LINE_FS;
                    gap_r <= 8'h00;
                    lst_r <= L_GAP;
                end
                L_GAP:
                begin
                    gap_r <= gap_r + 8'h01;
                    if (gap_r == HGAP - 8'h01)
                    begin
                        kind_r <= nk;
                        lnum_r <= nl;
                        if (nk == K_FE)
                        begin
                            fe_r <= 1'b1;
                            lst_r <= L_FE;
                        end
                        else
                        begin
                            emb_i_r <= (nk == K_EMB) && (kind_r == K_EMB);
                            lval_r <= 1'b1;
                            pval_r <= 1'b1;
                            pidx_r <= 12'h000;
                            data_r <= ((nk == K_EMB) && emb_on_r) ? snap_r[0] : 8'h00;
                            lst_r <= L_LINE;
                        end
                    end
                end
                L_LINE:
                begin
                    if (pidx_r == width_r - 12'd1)
                    begin
                        lval_r <= 1'b0;
                        pval_r <= 1'b0;
                        gap_r <= 8'h00;
                        lst_r <= L_GAP;
                    end
                    else
                    begin
                        pidx_r <= pnext;
                        // Disabled embedded slots still run, filled with zero.
                        if ((kind_r == K_EMB) && emb_on_r && (pnext < 12'd16))
                        begin
                            data_r <= snap_r[pnext[3:0]];
                        end
                        else
                        begin
                            data_r <= 8'h00;
                        end
                    end
                end
                L_FE:
                begin
                    lst_r <= L_REQ;
                end
            endcase
        end
    end

    assign line_valid = lval_r;
    assign line_kind = kind_r;
    assign line_num = lnum_r;
    assign pix_valid = pval_r;
    assign pix_idx = pidx_r;
    assign line_data = data_r;
    assign frame_start = fs_r;
    assign frame_end = fe_r;

    idle_release_a: assert property (@(posedge clk) disable iff (!nrst)
        st_r == S_IDLE |-> !sda_oe_r) else $error("sda driven while idle");
    addr_ack_a: assert property (@(posedge clk) disable iff (!nrst)
        byte_end && st_r == S_DEV && dev_hit |=> sda_oe_r && ack_r)
        else $error("own address not acked");
    foreign_addr_a: assert property (@(posedge clk) disable iff (!nrst)
        byte_end && st_r == S_DEV && !dev_hit |=> st_r == S_IDLE && !sda_oe_r)
        else $error("foreign address answered");
    read_dir_a: assert property (@(posedge clk) disable iff (!nrst)
        byte_end && st_r == S_DEV && dev_hit |=> (st_r == S_RD) == $past(sh_r[0]))
        else $error("direction bit misread");
    addr_step_a: assert property (@(posedge clk) disable iff (!nrst)
        wr_fire |=> addr_r == $past(addr_r) + 16'h0001) else $error("address not stepped");
    rsv_write_a: assert property (@(posedge clk) disable iff (!nrst)
        wr_fire && !in_cfg |=> $stable(cfg_r)) else $error("reserved write stored");
    rsv_read_a: assert property (@(posedge clk) disable iff (!nrst)
        addr_r >= BLK_RSV |-> rd_byte == 8'h00) else $error("reserved read not zero");
    row_parity_a: assert property (@(posedge lclk) disable iff (!lnrst)
        lval_r && (kind_r == K_RG || kind_r == K_GB) |-> (kind_r == K_RG) == lnum_r[0])
        else $error("row colour order broken");
    pd_line_a: assert property (@(posedge lclk) disable iff (!lnrst)
        lval_r && kind_r == K_PD |-> lnum_r == rows_r + PD_OFS) else $error("pd line misplaced");
    frame_end_a: assert property (@(posedge lclk) disable iff (!lnrst)
        fe_r |-> kind_r == K_FE && lnum_r == rows_r + GYRO_OFS) else $error("frame end misplaced");
    pix_width_a: assert property (@(posedge lclk) disable iff (!lnrst)
        pval_r |-> pidx_r < width_r) else $error("line too long");
    emb_data_a: assert property (@(posedge lclk) disable iff (!lnrst)
        pval_r && kind_r == K_EMB && emb_on_r && pidx_r < 12'd16
        |-> data_r == snap_r[pidx_r[3:0]]) else $error("embedded byte wrong");
endmodule // scp_top

// >>> scp_pkg.sv
// Constants and types for the sensor control port and frame layout block.
// Assumes a single design top that imports the whole package.
package scp_pkg;
    // Slave address pair selected by the strap pin; values are arbitrary.
    localparam logic [6:0] SADDR_LO = 7'h10;
    localparam logic [6:0] SADDR_HI = 7'h1a;
    // Address space blocks.
    localparam logic [15:0] BLK_RSV = 16'h1000;
    localparam logic [15:0] BLK_MAKER = 16'h3000;
    localparam int REG_DEPTH = 16;
    // Register indices inside the configuration block.
    localparam logic [3:0] IX_ID = 4'h0;
    localparam logic [3:0] IX_CTRL = 4'h1;
    localparam logic [3:0] IX_MODE = 4'h2;
    localparam int CTRL_STREAM = 0;
    localparam int CTRL_EMB = 1;
    // Identity byte; the value is arbitrary.
    localparam logic [7:0] ID_VAL = 8'h5a;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [1:0] MODE_FULL = 2'h0;
    localparam logic [1:0] MODE_BIN2 = 2'h1;
    localparam logic [1:0] MODE_BIN4 = 2'h2;
    // Frame geometry.
    localparam logic [11:0] ROWS_FULL = 12'd3040;
    localparam logic [11:0] ROWS_BIN2 = 12'd1520;
    localparam logic [11:0] ROWS_BIN4 = 12'd760;
    localparam logic [11:0] WIDTH_FULL = 12'd4056;
    localparam logic [11:0] WIDTH_BIN = 12'd2028;
    localparam logic [11:0] LINE_FS = 12'd1;
    localparam logic [11:0] LINE_EMB = 12'd2;
    localparam logic [11:0] LINE_ROW0 = 12'd3;
    localparam logic [11:0] PD_OFS = 12'd3;
    localparam logic [11:0] GYRO_OFS = 12'd4;
    localparam logic [7:0] HGAP = 8'd8;
    typedef enum logic [2:0] {K_FS, K_EMB, K_RG, K_GB, K_PD, K_GYRO, K_FE} scp_kind_t;
    typedef enum logic [2:0] {S_IDLE, S_DEV, S_AHI, S_ALO, S_WR, S_RD} scp_i2c_t;
    typedef enum logic [2:0] {L_REQ, L_WAIT, L_FS, L_LINE, L_GAP, L_FE} scp_link_t;
endpackage

// >>> scp_host.sv
// Two-wire bus master model that stands in for the host processor.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ps
module scp_host (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic m_oe
);
    initial
    begin
        scl = 1'b1;
        m_oe = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Each scl phase spans at least eight system clocks, twice what the port needs.
    task automatic start();
        m_oe = 1'b0;
        hold(4);
        scl = 1'b1;
        hold(6);
        m_oe = 1'b1;
        hold(6);
        scl = 1'b0;
        hold(4);
    endtask
    task automatic stop();
        m_oe = 1'b1;
        hold(4);
        scl = 1'b1;
        hold(6);
        m_oe = 1'b0;
        hold(8);
    endtask
    // A one is sent by releasing the wire, so reads simply send ones.
    task automatic bit_io(input logic b, output logic r);
        m_oe = ~b;
        hold(4);
        scl = 1'b1;
        hold(4);
        r = sda;
        hold(4);
        scl = 1'b0;
        hold(4);
    endtask
    task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
        output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(d[i], r);
            q[i] = r;
        end
        bit_io(last, r);
        ack = ~r;
    endtask
endmodule // scp_host

// >>> tb_top.sv
// Self-checking bench for the sensor control port and frame sequencer.
// Assumes scp_pkg and scp_top compiled first; frames are shortened by parameters.
`timescale 1ns/1ps
module tb_top
    import scp_pkg::*;
;
    localparam logic [11:0] RF = 12'h004, RB2 = 12'h003, RB4 = 12'h002;
    localparam logic [11:0] WF = 12'h014, WB = 12'h011;
    logic clk, nrst, lclk, scl, m_oe, strap, sda_o, sda_oe, line_valid, pix_valid;
    logic frame_start, frame_end, armed, chk_on, ex_emb, k;
    scp_kind_t line_kind;
    logic [11:0] line_num, pix_idx;
    logic [7:0] line_data, q;
    logic [7:0] ereg [16];
    logic [7:0] wq [$];
    logic [1:0] ex_mode;
    logic [6:0] dev_cur;
    logic [31:0] seed, r;
    logic [15:0] st;
    logic [15:0] rsv [5] = '{16'h0000, 16'h0010, 16'h1000, 16'h2fff, 16'h3000};
    int err_count, tests_run, fe_cnt, li, pc;
    wire sda = (sda_oe ? sda_o : 1'b1) & ~m_oe;
    scp_top #(.ROWS_F(RF), .ROWS_B2(RB2), .ROWS_B4(RB4), .WIDTH_F(WF), .WIDTH_B(WB)) u_scp_top (
        .clk(clk), .nrst(nrst), .lclk(lclk), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .addr_select_pin(strap), .line_valid(line_valid),
        .line_kind(line_kind), .line_num(line_num), .pix_valid(pix_valid), .pix_idx(pix_idx),
        .line_data(line_data), .frame_start(frame_start), .frame_end(frame_end));
    scp_host u_scp_host (.clk(clk), .sda(sda), .scl(scl), .m_oe(m_oe));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial
    begin
        lclk = 1'b0;
        #7.3;
        forever #24 lclk = ~lclk;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch t=%0t %s seen %h exp %h", $time, msg, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("counts: %0d compares, %0d mismatches", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    function automatic logic [7:0] exp_rd(input int m);
        return (m < 16) ? ereg[m] : 8'h00;
    endfunction
    function automatic logic [11:0] rows_of();
        return (ex_mode == MODE_FULL) ? RF : (ex_mode == MODE_BIN2) ? RB2 : RB4;
    endfunction
    function automatic scp_kind_t exp_kind(input int l);
        if (l < 2)
            return K_EMB;
        if (l == rows_of() + 2)
            return K_PD;
        if (l == rows_of() + 3)
            return K_GYRO;
        return l[0] ? K_GB : K_RG;
    endfunction
    function automatic logic [11:0] exp_num(input int l);
        return (l < 2) ? 12'h002 : 12'(l + 1);
    endfunction
    task automatic addr_ph(input logic [15:0] a, output logic ok);
        logic k1, k2, k3;
        u_scp_host.start();
        u_scp_host.xfer({dev_cur, 1'b0}, 1'b1, q, k1);
        u_scp_host.xfer(a[15:8], 1'b1, q, k2);
        u_scp_host.xfer(a[7:0], 1'b1, q, k3);
        ok = k1 & k2 & k3;
    endtask
    task automatic wr(input logic [15:0] a);
        logic ok;
        int n;
        addr_ph(a, ok);
        check(ok, 1'b1, "write address ack");
        foreach (wq[i])
        begin
            u_scp_host.xfer(wq[i], 1'b1, q, ok);
            check(ok, 1'b1, "write data ack");
            n = a + i;
            if (n >= 1 && n < 16)
                ereg[n] = wq[i];
        end
        u_scp_host.stop();
    endtask
    task automatic rd(input logic [15:0] a, input int n);
        logic ok;
        addr_ph(a, ok);
        u_scp_host.start();
        u_scp_host.xfer({dev_cur, 1'b1}, 1'b1, q, k);
        check(ok & k, 1'b1, "read address ack");
        for (int i = 0; i < n; i++)
        begin
            u_scp_host.xfer(8'hff, i == n - 1, q, k);
            check(q, exp_rd(a + i), "read data");
        end
        u_scp_host.stop();
    endtask
    task automatic run_mode(input logic [1:0] m, input logic e);
        int f;
        ex_mode = m;
        ex_emb = e;
        armed = 1'b1;
        f = fe_cnt;
        wq = '{{6'h00, m}};
        wr(16'h0002);
        wq = '{{6'h00, e, 1'b1}};
        wr(16'h0001);
        for (int i = 0; i < 20000 && fe_cnt == f; i++)
            @(negedge clk);
        check(16'(fe_cnt - f), 16'h0001, "frame seen");
        armed = 1'b0;
        wq = '{8'h00};
        wr(16'h0001);
        repeat (4000) @(negedge clk);
        $display("test mode %0d done", m);
    endtask
    always @(negedge lclk)
    begin
        if (frame_start)
        begin
            chk_on = armed;
            li = 0;
            pc = 0;
            if (chk_on)
                check({line_num, 1'b0, line_kind}, {12'h001, 1'b0, K_FS}, "start");
        end
        if (chk_on && line_valid)
        begin
            check({line_num, 1'b0, line_kind}, {exp_num(li), 1'b0, exp_kind(li)}, "kind");
            check({pix_valid, 3'h0, pix_idx}, {1'b1, 3'h0, pc[11:0]}, "pixel");
            if (line_kind == K_EMB)
                check(line_data, (ex_emb && pc < 16) ? ereg[pc] : 8'h00, "emb");
            else
                check(line_data, 8'h00, "row data");
            pc++;
        end
        else if (chk_on && pc != 0)
        begin
            check(pc[15:0], (ex_mode == MODE_FULL) ? WF : WB, "width");
            li++;
            pc = 0;
        end
        if (chk_on && frame_end)
        begin
            check({line_num, 1'b0, line_kind}, {rows_of() + 12'h004, 1'b0, K_FE}, "end");
            check(li[15:0], rows_of() + 16'h0004, "line count");
            fe_cnt++;
        end
    end
    initial
    begin
        #500000;
        err_count++;
        conclude();
    end
    initial
    begin
        seed = 32'h9c5ec6c0;
        {err_count, tests_run, fe_cnt, li, pc} = '0;
        {nrst, strap, armed, chk_on, ex_emb} = '0;
        ex_mode = MODE_FULL;
        dev_cur = SADDR_LO;
        foreach (ereg[i])
            ereg[i] = 8'h00;
        ereg[0] = ID_VAL;
        repeat (8) @(posedge lclk);
        @(negedge clk);
        check({sda_oe, sda_o, line_valid, frame_start}, 16'h0000, "reset outputs");
        nrst = 1'b1;
        repeat (40) @(negedge clk);
        rd(16'h0000, 3);
        $display("test id done");
        u_scp_host.start();
        u_scp_host.xfer({SADDR_HI, 1'b0}, 1'b1, q, k);
        check(k, 1'b0, "foreign address ack");
        u_scp_host.stop();
        strap = 1'b1;
        dev_cur = SADDR_HI;
        repeat (8) @(negedge clk);
        rd(16'h0000, 1);
        strap = 1'b0;
        dev_cur = SADDR_LO;
        repeat (8) @(negedge clk);
        rd(16'h0000, 1);
        $display("test address done");
        repeat (3)
        begin
            r = $random(seed);
            st = {13'h0000, r[2:0]} + 16'h0003;
            wq.delete();
            repeat (6) wq.push_back(8'($random(seed)));
            wr(st);
            rd(st, 6);
        end
        $display("test burst done");
        foreach (rsv[i])
        begin
            wq = '{8'h3c};
            wr(rsv[i]);
            rd(rsv[i], 1);
        end
        $display("test reserved done");
        run_mode(MODE_FULL, 1'b1);
        run_mode(MODE_BIN2, 1'b0);
        run_mode(MODE_BIN4, 1'b1);
        conclude();
    end
endmodule // tb_top
